// ### single_wire_pkg.sv
// How it works
// - Host bit cycle lasts at least 190 us.
// - Device reply bit cycle 190..250 us, nominal 205.
// - Host one: low 0.5..50 us, then released.
// - Device one: low 32..50 us, then released.
// - Host zero: low 86..145 us.
// - Device zero: low 80..145 us.
// - Device reply starts 190..950 us after request.
// - Host commands read or write device locations.
// - Device holds two 32-byte user blocks.
package single_wire_pkg;

  // ***************************************************************
  // Clock and counters
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int CNT_W = 20;

  // ***************************************************************
  // Link times in microseconds and their cycle counts
  // ***************************************************************
  localparam int HOST_CYC_MIN_US = 190;
  localparam int HOST_CYC_US = 200;
  localparam int HOST_CYC_CYC = (HOST_CYC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_W1_US = 10;
  localparam int HOST_W1_CYC = (HOST_W1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_W0_US = 110;
  localparam int HOST_W0_CYC = (HOST_W0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BREAK_MIN_US = 190;
  localparam int HOST_BREAK_US = 200;
  localparam int HOST_BREAK_CYC = (HOST_BREAK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_MIN_US = 40;
  localparam int HOST_RECOV_US = 50;
  localparam int HOST_RECOV_CYC = (HOST_RECOV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEV_CYC_US = 205;
  localparam int DEV_CYC_CYC = DEV_CYC_US * 1000 / CLK_PERIOD_NS;
  localparam int DEV_W1_US = 40;
  localparam int DEV_W1_CYC = DEV_W1_US * 1000 / CLK_PERIOD_NS;
  localparam int DEV_W0_US = 110;
  localparam int DEV_W0_CYC = DEV_W0_US * 1000 / CLK_PERIOD_NS;
  localparam int RSP_MIN_US = 190;
  localparam int RSP_MAX_US = 950;
  localparam int DEV_RSP_US = 400;
  localparam int DEV_RSP_CYC = (DEV_RSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_TIMEOUT_US = 1000;
  localparam int HOST_TIMEOUT_CYC = HOST_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int BIT_SPLIT_US = 65;
  localparam int BIT_SPLIT_CYC = BIT_SPLIT_US * 1000 / CLK_PERIOD_NS;
  localparam int BREAK_DET_US = 160;
  localparam int BREAK_DET_CYC = BREAK_DET_US * 1000 / CLK_PERIOD_NS;

  // ***************************************************************
  // Frame and memory layout
  // ***************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WRITE_BIT = 15;
  localparam int FRAME_W = 16;
  localparam int CMD_LAST_BIT = 7;
  localparam int WR_LAST_BIT = 15;
  localparam int MEM_BYTES = 128;
  localparam logic [6:0] USER_A_BASE = 7'h40;
  localparam logic [6:0] USER_B_BASE = 7'h60;
  localparam int USER_BLOCK_BYTES = 32;
  localparam int FIFO_DEPTH = 8;

endpackage : single_wire_pkg

// ### single_wire_if.sv
`timescale 1ns/1ps
`default_nettype none
interface single_wire_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  wire single_wire_host_line;

  // Open-drain wired AND with an external pull-up.
  assign single_wire_host_line = !((host_oe && !host_o) || (dev_oe && !dev_o));

  modport host (output host_o, output host_oe, input single_wire_host_line);
  modport device (output dev_o, output dev_oe, input single_wire_host_line);
endinterface : single_wire_if
`default_nettype wire

// ### single_wire_device.sv
`timescale 1ns/1ps
`default_nettype none
module single_wire_device
  import single_wire_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEV_CYCLE = CNT_W'(DEV_CYC_CYC),
  parameter logic [CNT_W-1:0] DEV_RESPONSE = CNT_W'(DEV_RSP_CYC),
  parameter logic [CNT_W-1:0] DEV_ZERO_LOW = CNT_W'(DEV_W0_CYC),
  parameter logic [CNT_W-1:0] DEV_ONE_LOW = CNT_W'(DEV_W1_CYC),
  parameter logic [CNT_W-1:0] BIT_SPLIT = CNT_W'(BIT_SPLIT_CYC),
  parameter logic [CNT_W-1:0] BREAK_DETECT = CNT_W'(BREAK_DET_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  single_wire_if.device link,
  input wire logic gauge_wr_en,
  input wire logic [ADDR_W-1:0] gauge_wr_addr,
  input wire logic [DATA_W-1:0] gauge_wr_data,
  output logic exec_valid,
  output logic exec_write,
  output logic [ADDR_W-1:0] exec_addr,
  output logic [DATA_W-1:0] exec_data
);

  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_RX = 4'b0010,
    D_RSP = 4'b0100,
    D_TX = 4'b1000
  } dev_state_t;

  dev_state_t state;
  dev_state_t next_state;
  logic line_m;
  logic line_s;
  logic line_d;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] tmr;
  logic [FRAME_W-1:0] rx_sh;
  logic [4:0] bit_cnt;
  logic [DATA_W-1:0] tx_sh;
  logic oe;
  logic [DATA_W-1:0] mem [MEM_BYTES];

  // ***************************************************************
  // Line sampling and pulse measurement
  // ***************************************************************
  wire fall = line_d && !line_s;
  wire rise = !line_d && line_s;
  wire listening = state != D_TX;
  wire host_bit = low_cnt < BIT_SPLIT;
  wire brk = listening && rise && low_cnt >= BREAK_DETECT;
  wire bit_in = rise && state == D_RX && low_cnt < BREAK_DETECT;
  wire [FRAME_W-1:0] next_rx_sh = {host_bit, rx_sh[FRAME_W-1:1]};
  wire cmd_done = bit_in && bit_cnt == 5'(CMD_LAST_BIT);
  wire rd_done = cmd_done && !next_rx_sh[WRITE_BIT];
  wire wr_done = bit_in && bit_cnt == 5'(WR_LAST_BIT);
  wire [ADDR_W-1:0] cmd_addr = next_rx_sh[FRAME_W-2:DATA_W];
  wire [ADDR_W-1:0] wr_addr = next_rx_sh[ADDR_W-1:0];
  wire [DATA_W-1:0] wr_data = next_rx_sh[FRAME_W-1:DATA_W];
  wire tx_bit_end = state == D_TX && tmr == DEV_CYCLE - 1'b1;
  wire [CNT_W-1:0] low_len = tx_sh[0] ? DEV_ONE_LOW : DEV_ZERO_LOW;
  wire gauge_ok = gauge_wr_en && gauge_wr_addr < USER_A_BASE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_d <= 1'b1;
    end else begin
      line_m <= link.single_wire_host_line;
      line_s <= line_m;
      line_d <= line_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else if (fall) begin
      low_cnt <= CNT_W'(1);
    end else if (!line_s && low_cnt != '1) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    next_state = state;
    case (state)
      D_IDLE: begin
        if (brk) begin
          next_state = D_RX;
        end
      end
      D_RX: begin
        if (brk) begin
          next_state = D_RX;
        end else if (rd_done) begin
          next_state = D_RSP;
        end else if (wr_done) begin
          next_state = D_IDLE;
        end
      end
      D_RSP: begin
        if (brk) begin
          next_state = D_RX;
        end else if (tmr == DEV_RESPONSE - 1'b1) begin
          next_state = D_TX;
        end
      end
      D_TX: begin
        if (tx_bit_end && bit_cnt == 5'(CMD_LAST_BIT)) begin
          next_state = D_IDLE;
        end
      end
      default: next_state = D_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= D_IDLE;
      tmr <= '0;
      bit_cnt <= '0;
      rx_sh <= '0;
      tx_sh <= '0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      if (state != next_state || brk || tx_bit_end) begin
        tmr <= '0;
      end else begin
        tmr <= tmr + 1'b1;
      end
      if (state != next_state || brk) begin
        bit_cnt <= '0;
      end else if (bit_in || tx_bit_end) begin
        bit_cnt <= bit_cnt + 5'(1);
      end
      if (bit_in) begin
        rx_sh <= next_rx_sh;
      end
      if (rd_done) begin
        tx_sh <= mem[cmd_addr];
      end else if (tx_bit_end) begin
        tx_sh <= {1'b0, tx_sh[DATA_W-1:1]};
      end
      oe <= state == D_TX && tmr < low_len;
    end
  end

  // ***************************************************************
  // Register and user storage, 0x40-0x5f and 0x60-0x7f user blocks
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (gauge_ok) begin
      mem[gauge_wr_addr] <= gauge_wr_data;
    end
    if (wr_done) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_valid <= 1'b0;
      exec_write <= 1'b0;
      exec_addr <= '0;
      exec_data <= '0;
      link.dev_o <= 1'b0;
      link.dev_oe <= 1'b0;
    end else begin
      exec_valid <= rd_done || wr_done;
      if (rd_done) begin
        exec_write <= 1'b0;
        exec_addr <= cmd_addr;
        exec_data <= mem[cmd_addr];
      end else if (wr_done) begin
        exec_write <= 1'b1;
        exec_addr <= wr_addr;
        exec_data <= wr_data;
      end
      link.dev_o <= 1'b0;
      link.dev_oe <= oe;
    end
  end

endmodule : single_wire_device
`default_nettype wire

// ### single_wire_host.sv
`timescale 1ns/1ps
`default_nettype none
module single_wire_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      if (push) begin
        wp <= wp + AW'(1);
      end
      if (pop) begin
        rp <= rp + AW'(1);
      end
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule : single_wire_fifo

module single_wire_host
  import single_wire_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOST_CYCLE = CNT_W'(HOST_CYC_CYC),
  parameter logic [CNT_W-1:0] HOST_ONE_LOW = CNT_W'(HOST_W1_CYC),
  parameter logic [CNT_W-1:0] HOST_ZERO_LOW = CNT_W'(HOST_W0_CYC),
  parameter logic [CNT_W-1:0] HOST_BREAK = CNT_W'(HOST_BREAK_CYC),
  parameter logic [CNT_W-1:0] HOST_RECOVERY = CNT_W'(HOST_RECOV_CYC),
  parameter logic [CNT_W-1:0] HOST_TIMEOUT = CNT_W'(HOST_TIMEOUT_CYC),
  parameter logic [CNT_W-1:0] BIT_SPLIT = CNT_W'(BIT_SPLIT_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  single_wire_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_timeout,
  output logic busy
);

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_BRK = 5'b00010,
    H_REC = 5'b00100,
    H_TX = 5'b01000,
    H_RX = 5'b10000
  } host_state_t;

  host_state_t state;
  host_state_t next_state;
  logic line_m;
  logic line_s;
  logic line_d;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] tmr;
  logic [FRAME_W-1:0] tx_sh;
  logic [4:0] bit_cnt;
  logic is_read;
  logic [DATA_W-1:0] rx_sh;
  logic oe;
  logic q_valid;
  logic [FRAME_W-1:0] q_data;

  // ***************************************************************
  // Command queue
  // ***************************************************************
  single_wire_fifo #(
    .W(FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_write, cmd_addr, cmd_data}),
    .out_valid(q_valid),
    .out_ready(state == H_IDLE),
    .out_data(q_data)
  );

  // ***************************************************************
  // Decode
  // ***************************************************************
  wire pop = q_valid && state == H_IDLE;
  wire fall = line_d && !line_s;
  wire rise = !line_d && line_s;
  wire [CNT_W-1:0] low_len = tx_sh[0] ? HOST_ONE_LOW : HOST_ZERO_LOW;
  wire tx_bit_end = state == H_TX && tmr == HOST_CYCLE - 1'b1;
  wire [4:0] tx_last = is_read ? 5'(CMD_LAST_BIT) : 5'(WR_LAST_BIT);
  wire rx_bit = state == H_RX && rise;
  wire rx_value = low_cnt < BIT_SPLIT;
  wire rx_last = rx_bit && bit_cnt == 5'(CMD_LAST_BIT);
  wire rx_expired = state == H_RX && tmr >= HOST_TIMEOUT;

  always_comb begin
    next_state = state;
    case (state)
      H_IDLE: begin
        if (pop) begin
          next_state = H_BRK;
        end
      end
      H_BRK: begin
        if (tmr == HOST_BREAK - 1'b1) begin
          next_state = H_REC;
        end
      end
      H_REC: begin
        if (tmr == HOST_RECOVERY - 1'b1) begin
          next_state = H_TX;
        end
      end
      H_TX: begin
        if (tx_bit_end && bit_cnt == tx_last) begin
          next_state = is_read ? H_RX : H_IDLE;
        end
      end
      H_RX: begin
        if (rx_expired || rx_last) begin
          next_state = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  // ***************************************************************
  // Line sampling
  // ***************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_d <= 1'b1;
    end else begin
      line_m <= link.single_wire_host_line;
      line_s <= line_m;
      line_d <= line_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else if (fall) begin
      low_cnt <= CNT_W'(1);
    end else if (!line_s && low_cnt != '1) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE;
      tmr <= '0;
      bit_cnt <= '0;
      tx_sh <= '0;
      is_read <= 1'b0;
      rx_sh <= '0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      // The reply timer restarts on every falling edge from the device.
      if (state != next_state || state == H_IDLE || tx_bit_end || (state == H_RX && fall)) begin
        tmr <= '0;
      end else begin
        tmr <= tmr + 1'b1;
      end
      if (state != next_state) begin
        bit_cnt <= '0;
      end else if (tx_bit_end || rx_bit) begin
        bit_cnt <= bit_cnt + 5'(1);
      end
      if (pop) begin
        tx_sh <= {q_data[DATA_W-1:0], q_data[FRAME_W-1:DATA_W]};
        is_read <= !q_data[WRITE_BIT];
      end else if (tx_bit_end) begin
        tx_sh <= {1'b0, tx_sh[FRAME_W-1:1]};
      end
      if (rx_bit) begin
        rx_sh <= {rx_value, rx_sh[DATA_W-1:1]};
      end
      oe <= state == H_BRK || (state == H_TX && tmr < low_len);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_timeout <= 1'b0;
      busy <= 1'b0;
      link.host_o <= 1'b0;
      link.host_oe <= 1'b0;
    end else begin
      rd_valid <= rx_last;
      if (rx_last) begin
        rd_data <= {rx_value, rx_sh[DATA_W-1:1]};
      end
      rd_timeout <= rx_expired && !rx_last;
      busy <= next_state != H_IDLE;
      link.host_o <= 1'b0;
      link.host_oe <= oe;
    end
  end

endmodule : single_wire_host
`default_nettype wire

// ### single_wire_chk.sv
`timescale 1ns/1ps
`default_nettype none
module single_wire_chk #(
  parameter int H1 = 32'h9c4,
  parameter int H0 = 32'h1f40,
  parameter int HB = 32'h2af8,
  parameter int HR = 32'h3e8,
  parameter int HC = 32'h2ee0,
  parameter int D1 = 32'h9c4,
  parameter int D0 = 32'h1f40,
  parameter int DC = 32'h2ee0,
  parameter int DR = 32'h4e20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic single_wire_host_line
);
  // ******************************
  // Pulse and gap counters
  // ******************************
  localparam int SAT = 32'h100000;
  logic hp, dp, brk;
  int hw, hi, hg, dw, dg;
  wire h_rise = host_oe && !hp;
  wire h_fall = !host_oe && hp;
  wire d_rise = dev_oe && !dp;
  wire d_fall = !dev_oe && dp;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hp <= 1'b0;
      dp <= 1'b0;
      brk <= 1'b0;
      hw <= 0;
      hi <= 0;
      hg <= SAT;
      dw <= 0;
      dg <= SAT;
    end else begin
      hp <= host_oe;
      dp <= dev_oe;
      brk <= h_rise ? 1'b0 : ((h_fall && hw == HB) ? 1'b1 : brk);
      hw <= host_oe ? hw + 1 : 0;
      hi <= host_oe ? 0 : (hi < SAT ? hi + 1 : hi);
      hg <= h_rise ? 1 : (hg < SAT ? hg + 1 : hg);
      dw <= dev_oe ? dw + 1 : 0;
      dg <= d_rise ? 1 : (dg < SAT ? dg + 1 : dg);
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence first_bit_s; h_rise && brk; endsequence
  sequence reply_start_s; d_rise && dg > 2 * DC; endsequence
  sequence reply_next_s; d_rise && dg <= 2 * DC; endsequence

  host_width_a: assert property (h_fall |-> hw == H1 || hw == H0 || hw == HB)
    else $error("host low pulse has a wrong width");
  host_cycle_a: assert property (h_rise |-> hg >= HC)
    else $error("host bit cycle too short");
  break_recov_a: assert property (first_bit_s |-> hi == HR)
    else $error("recovery after break has a wrong length");
  dev_width_a: assert property (d_fall |-> dw == D1 || dw == D0)
    else $error("device low pulse has a wrong width");
  dev_cycle_a: assert property (reply_next_s |-> dg == DC)
    else $error("device bit cycle has a wrong length");
  dev_resp_a: assert property (reply_start_s |-> hi inside {[DR:DR + 8]})
    else $error("device reply starts outside its window");
  no_overlap_a: assert property (!(host_oe && dev_oe))
    else $error("host and device pull the line together");
  od_drive_a: assert property ((host_oe || dev_oe) == !single_wire_host_line)
    else $error("line level does not follow the pull-downs");
  od_value_a: assert property ((host_oe |-> !host_o) and (dev_oe |-> !dev_o))
    else $error("a party drives the line high");
endmodule : single_wire_chk
`default_nettype wire

// ### tb_single_wire_host_link.sv
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_host_link import single_wire_pkg::*;;
  // ******************************
  // Shortened link times in cycles
  // ******************************
  // One clock cycle stands for one microsecond, so a whole run stays short.
  localparam logic [19:0] T_CYC = 20'h000c8;
  localparam logic [19:0] T_H1 = 20'h0000a;
  localparam logic [19:0] T_H0 = 20'h0006e;
  localparam logic [19:0] T_BRK = 20'h000c8;
  localparam logic [19:0] T_REC = 20'h00032;
  localparam logic [19:0] T_RSP = 20'h00190;
  localparam logic [19:0] T_D1 = 20'h00028;
  localparam logic [19:0] T_SPLIT = 20'h00041;
  localparam logic [19:0] T_DET = 20'h000a0;
  localparam logic [19:0] T_TMO = 20'h003e8;
  localparam int LIM = 32'h00002710;
  logic clk, reset_n, cmd_valid, cmd_ready, cmd_write, rd_valid, rd_timeout, busy;
  logic gauge_wr_en, exec_valid, exec_write;
  logic [6:0] cmd_addr, gauge_wr_addr, exec_addr;
  logic [7:0] cmd_data, rd_data, gauge_wr_data, exec_data;
  int num_errors = 0;
  int n_checks = 0;

  single_wire_if link_if();
  single_wire_host #(.HOST_CYCLE(T_CYC), .HOST_ONE_LOW(T_H1), .HOST_ZERO_LOW(T_H0), .HOST_BREAK(T_BRK),
    .HOST_RECOVERY(T_REC), .HOST_TIMEOUT(T_TMO), .BIT_SPLIT(T_SPLIT)) i_single_wire_host (.clk(clk),
    .reset_n(reset_n),
    .link(link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rd_valid(rd_valid), .rd_data(rd_data), .rd_timeout(rd_timeout), .busy(busy));
  single_wire_device #(.DEV_CYCLE(T_CYC), .DEV_RESPONSE(T_RSP), .DEV_ZERO_LOW(T_H0), .DEV_ONE_LOW(T_D1),
    .BIT_SPLIT(T_SPLIT), .BREAK_DETECT(T_DET)) i_single_wire_device (.clk(clk), .reset_n(reset_n),
    .link(link_if), .gauge_wr_en(gauge_wr_en), .gauge_wr_addr(gauge_wr_addr), .gauge_wr_data(gauge_wr_data),
    .exec_valid(exec_valid), .exec_write(exec_write), .exec_addr(exec_addr), .exec_data(exec_data));
  single_wire_chk #(.H1(T_H1), .H0(T_H0), .HB(T_BRK), .HR(T_REC), .HC(T_CYC), .D1(T_D1), .D0(T_H0),
    .DC(T_CYC), .DR(T_RSP)) i_single_wire_chk (.clk(clk), .reset_n(reset_n), .host_o(link_if.host_o),
    .host_oe(link_if.host_oe), .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe),
    .single_wire_host_line(link_if.single_wire_host_line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waits for a read result when rd is set, else for an executed command.
  task automatic await(input logic rd);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > LIM) begin
        check("wait", 16'h0001, 16'h0000);
        close_out();
      end
    end while (rd ? (rd_valid !== 1'b1 && rd_timeout !== 1'b1) : exec_valid !== 1'b1);
  endtask : await

  task automatic expect_exec(input logic w, input logic [6:0] a, input logic [7:0] d);
    await(1'b0);
    check("exec_write", 16'(w), 16'(exec_write));
    check("exec_addr", 16'(a), 16'(exec_addr));
    check("exec_data", 16'(d), 16'(exec_data));
    @(negedge clk);
  endtask : expect_exec

  task automatic expect_rd(input logic [7:0] d);
    await(1'b1);
    check("rd_valid", 16'h0001, 16'(rd_valid));
    check("rd_timeout", 16'h0000, 16'(rd_timeout));
    check("rd_data", 16'(d), 16'(rd_data));
  endtask : expect_rd

  task automatic t_user_block;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_addr <= 7'h7f;
    cmd_data <= 8'h3c;
    @(posedge clk);
    cmd_write <= 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    expect_exec(1'b1, 7'h7f, 8'h3c);
    check("busy", 16'h0001, 16'(busy));
    @(posedge clk);
    gauge_wr_en <= 1'b1;
    gauge_wr_addr <= 7'h7f;
    gauge_wr_data <= 8'h00;
    @(posedge clk);
    gauge_wr_en <= 1'b0;
    expect_exec(1'b0, 7'h7f, 8'h3c);
    expect_rd(8'h3c);
    $display("test user_block done");
  endtask : t_user_block

  task automatic t_gauge_path;
    @(posedge clk);
    gauge_wr_en <= 1'b1;
    gauge_wr_addr <= 7'h05;
    gauge_wr_data <= 8'h96;
    cmd_valid <= 1'b1;
    cmd_addr <= 7'h05;
    @(posedge clk);
    gauge_wr_en <= 1'b0;
    cmd_valid <= 1'b0;
    expect_exec(1'b0, 7'h05, 8'h96);
    expect_rd(8'h96);
    $display("test gauge_path done");
  endtask : t_gauge_path

  task automatic t_fifo_fill;
    int n;
    int m;
    n = 0;
    m = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_addr <= 7'h10;
    cmd_data <= 8'h50;
    @(negedge clk);
    while (cmd_ready === 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
      cmd_addr <= 7'h10 + 7'(n);
      cmd_data <= 8'h50 + 8'(n);
      @(negedge clk);
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    // The first entry has already left for the link, so the queue takes one more than its depth.
    check("fifo_fill", 16'(FIFO_DEPTH + 1), 16'(n));
    for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
      expect_exec(1'b1, 7'h10 + 7'(i), 8'h50 + 8'(i));
    end
    repeat (4000) begin
      @(negedge clk);
      if (exec_valid === 1'b1) m++;
    end
    check("fifo_refused", 16'h0000, 16'(m));
    check("busy", 16'h0000, 16'(busy));
    $display("test fifo_fill done");
  endtask : t_fifo_fill

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 8'h00;
    gauge_wr_en = 1'b0;
    gauge_wr_addr = 7'h00;
    gauge_wr_data = 8'h00;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_user_block();
    t_gauge_path();
    t_fifo_fill();
    close_out();
  end
endmodule : tb_single_wire_host_link
`default_nettype wire
